// file: hw/spc_command_slave.sv
// spc_command_slave: serial front end and command decoder of a dual volatile pot.
// assumes: sck, sdi and both selects come from pins; cond_bits is mclk logic.
`timescale 1ns/1ps
module spc_command_slave (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire spc_pkg::spc_pins_t pins_in,
  input  wire logic [8:0]       cond_bits,
  output logic                  sdo,
  output logic                  sdo_oe,
  output spc_pkg::spc_pot_t     pot,
  output logic                  command_error_flag,
  output logic                  mode_one_one
);
  import spc_pkg::*;

  spc_pins_t   pins_s;
  logic        sck_d_reg;
  logic        active_reg;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [14:0] shift_reg;
  logic [3:0]  addr_reg;
  logic [1:0]  op_reg;
  logic        err_reg;
  logic [8:0]  rd_reg;
  logic        sdo_reg;
  logic        sdo_next;
  logic        oe_reg;
  logic        mode_reg;
  logic [8:0]  wiper_reg [2];
  logic [8:0]  terminal_connect_control_reg;

  // pins pass two flops before any logic sees them
  spc_pin_sync #(
    .WIDTH     ($bits(spc_pins_t)),
    .RESET_VAL (PINS_IDLE)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (pins_in),
    .sync_out (pins_s)
  );

  // frame and sck edge detection
  wire active    = ~pins_s.cs_n | pins_s.cs_hv;
  wire act_start = active & ~active_reg;
  wire frame_on  = active & active_reg;
  wire sck_rise  = frame_on & pins_s.sck & ~sck_d_reg;
  wire sck_fall  = frame_on & ~pins_s.sck & sck_d_reg;

  // command head: address then operation, msb first
  wire [5:0] head      = {shift_reg[4:0], pins_s.sdi};
  wire [3:0] head_addr = head[5:2];
  wire [1:0] head_op   = head[1:0];
  wire head_wiper = (head_addr == ADDR_WIPER0) | (head_addr == ADDR_WIPER1);
  wire head_rw    = (head_op == OP_READ) | (head_op == OP_WRITE);
  wire head_terminal_connect_control  = (head_addr == ADDR_TERMINAL_CONNECT_CONTROL) & head_rw;
  wire head_cond  = (head_addr == ADDR_COND) & (head_op == OP_READ);
  wire head_valid = head_wiper | head_terminal_connect_control | head_cond;
  wire decode_now = sck_rise & (cnt_reg == POS_DECODE);
  wire new_err    = decode_now & ~head_valid;

  // read source chosen by the incoming address
  wire [8:0] head_rd = (head_addr == ADDR_WIPER0) ? wiper_reg[0] :
                       (head_addr == ADDR_WIPER1) ? wiper_reg[1] :
                       (head_addr == ADDR_TERMINAL_CONNECT_CONTROL)   ? terminal_connect_control_reg     : cond_bits;

  // 16-bit word; top data bit of the word at position 6 is dropped
  wire [15:0] word    = {shift_reg, pins_s.sdi};
  wire [8:0]  wr_data = word[8:0];

  // command boundaries and execution strobes
  wire byte_end  = sck_rise & (cnt_reg == POS_BYTE_END);
  wire word_end  = sck_rise & (cnt_reg == POS_WORD_END);
  wire short_cmd = (op_reg == OP_INC) | (op_reg == OP_DEC);
  wire do_write  = word_end & ~err_reg & (op_reg == OP_WRITE);
  wire do_inc    = byte_end & ~err_reg & (op_reg == OP_INC);
  wire do_dec    = byte_end & ~err_reg & (op_reg == OP_DEC);

  // bit counter: cleared outside and at start of frame, wraps per command
  always_comb
  begin
    cnt_next = cnt_reg;
    if (!active || act_start)
      cnt_next = 4'h0;
    else if (sck_rise && byte_end && short_cmd)
      cnt_next = 4'h0;
    else if (sck_rise)
      cnt_next = cnt_reg + 4'h1;
  end

  // sdo value for the bit position now starting
  wire [3:0] rd_idx   = POS_WORD_END - cnt_reg;
  wire       in_data  = (cnt_reg >= POS_BYTE_END) & (op_reg == OP_READ);
  wire       data_bit = rd_reg[rd_idx];
  always_comb
  begin
    sdo_next = sdo_reg;
    if (!active || act_start)
      sdo_next = 1'b1;
    else if (sck_fall && err_reg)
      sdo_next = 1'b0;
    else if (sck_fall && in_data)
      sdo_next = data_bit;
    else if (sck_fall)
      sdo_next = 1'b1;
  end

  // edge history and frame state
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sck_d_reg  <= 1'b0;
      active_reg <= 1'b0;
      cnt_reg    <= 4'h0;
      sdo_reg    <= 1'b1;
      oe_reg     <= 1'b0;
    end
    else
    begin
      sck_d_reg  <= pins_s.sck;
      active_reg <= active;
      cnt_reg    <= cnt_next;
      sdo_reg    <= sdo_next;
      oe_reg     <= active;
    end
  end

  // shift register of received bits
  always_ff @(posedge mclk)
  begin
    if (rst || !active)
      shift_reg <= '0;
    else if (sck_rise)
      shift_reg <= word[14:0];
  end

  // decoded command and sticky error
  always_ff @(posedge mclk)
  begin
    if (rst || !active)
    begin
      addr_reg <= 4'h0;
      op_reg   <= OP_WRITE;
      err_reg  <= 1'b0;
      rd_reg   <= ZERO_SCALE;
    end
    else if (decode_now && !err_reg)
    begin
      addr_reg <= head_addr;
      op_reg   <= head_op;
      err_reg  <= new_err;
      rd_reg   <= head_rd;
    end
  end

  // mode caught from sck level when select goes active
  always_ff @(posedge mclk)
  begin
    if (rst)
      mode_reg <= 1'b0;
    else if (act_start)
      mode_reg <= pins_s.sck;
  end

  // wiper storage, one entry per wiper
  genvar w;
  generate
    for (w = 0; w < 2; w++)
    begin : g_wiper
      wire hit   = (addr_reg == 4'(w));
      wire below = wiper_reg[w] < FULL_SCALE;
      wire above = wiper_reg[w] != ZERO_SCALE;
      always_ff @(posedge mclk)
      begin
        if (rst)
          wiper_reg[w] <= WIPER_RESET;
        else if (do_write && hit)
          wiper_reg[w] <= wr_data;
        else if (do_inc && hit && below)
          wiper_reg[w] <= wiper_reg[w] + ONE_STEP;
        else if (do_dec && hit && above)
          wiper_reg[w] <= wiper_reg[w] - ONE_STEP;
      end
    end
  endgenerate

  // terminal control storage
  always_ff @(posedge mclk)
  begin
    if (rst)
      terminal_connect_control_reg <= TERMINAL_CONNECT_CONTROL_RESET;
    else if (do_write && (addr_reg == ADDR_TERMINAL_CONNECT_CONTROL))
      terminal_connect_control_reg <= wr_data;
  end

  // outputs
  assign sdo                = sdo_reg;
  assign sdo_oe             = oe_reg;
  assign pot.wiper0         = wiper_reg[0];
  assign pot.wiper1         = wiper_reg[1];
  assign pot.terminal_connect_control           = terminal_connect_control_reg;
  assign command_error_flag = err_reg;
  assign mode_one_one       = mode_reg;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_start_clears: assert property (act_start |=> (cnt_reg == 4'h0) && sdo_reg && oe_reg)
    else $error("frame start did not clear counter or drive sdo");

  a_idle_quiet: assert property (!active ##1 !active |=> !oe_reg && !err_reg && (cnt_reg == 4'h0))
    else $error("serial logic not held reset while deselected");

  a_prefix_high: assert property (sck_fall && !err_reg && (cnt_reg < POS_FLAG) |=> sdo_reg)
    else $error("sdo not high during command head");

  a_flag_position: assert property (sck_fall && (cnt_reg == POS_FLAG) |=> sdo_reg == !$past(err_reg))
    else $error("error flag wrong at seventh bit");

  a_error_holds_low: assert property (err_reg && sck_fall |=> !sdo_reg)
    else $error("sdo not low after command error");

  a_error_sticky: assert property (err_reg && active |=> err_reg)
    else $error("error cleared while select active");

  a_invalid_sets_err: assert property (decode_now && !head_valid && !err_reg |=> err_reg [*2])
    else $error("invalid pair did not latch error");

  a_inc_step: assert property (do_inc && (addr_reg == ADDR_WIPER0) && (wiper_reg[0] < FULL_SCALE)
                               |=> wiper_reg[0] == $past(wiper_reg[0]) + ONE_STEP)
    else $error("increment did not add one");

  a_dec_floor: assert property (do_dec && (addr_reg == ADDR_WIPER1) && (wiper_reg[1] == ZERO_SCALE)
                                |=> wiper_reg[1] == ZERO_SCALE)
    else $error("decrement wrapped below zero");

  a_dec_step: assert property (do_dec && (addr_reg == ADDR_WIPER1) && (wiper_reg[1] != ZERO_SCALE)
                               |=> wiper_reg[1] == $past(wiper_reg[1]) - ONE_STEP)
    else $error("decrement did not subtract one");

  a_inc_ceiling: assert property (do_inc && (addr_reg == ADDR_WIPER1) && (wiper_reg[1] >= FULL_SCALE)
                                  |=> $stable(wiper_reg[1]))
    else $error("increment went past full scale");

  a_write_lands: assert property (do_write && (addr_reg == ADDR_WIPER0) |=> wiper_reg[0] == $past(wr_data))
    else $error("write did not land in wiper");

  a_mode_capture: assert property (act_start |=> mode_one_one == $past(pins_s.sck))
    else $error("mode not caught at select");

  a_write_gated: assert property ($changed(terminal_connect_control_reg) |-> $past(do_write) && ($past(cnt_reg) == POS_WORD_END))
    else $error("terminal control changed outside a full write");

  a_read_data: assert property (sck_fall && in_data && !err_reg |=> sdo_reg == $past(data_bit))
    else $error("read data bit wrong");

  c_read_done: cover property (word_end && (op_reg == OP_READ) && !err_reg);
  c_write_done: cover property (do_write);
  c_inc_then_dec: cover property (do_inc ##[1:1000] do_dec);
  c_error_seen: cover property (new_err);

endmodule : spc_command_slave

// file: hw/spc_pin_sync.sv
// spc_pin_sync: two-flop synchroniser, one chain per bit.
// assumes: inputs are asynchronous to mclk; rst is synchronous.
`timescale 1ns/1ps
module spc_pin_sync #(
  parameter int unsigned         WIDTH     = 4,
  parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [WIDTH-1:0]  async_in,
  output logic      [WIDTH-1:0]  sync_out
);

  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta_reg;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          meta_reg[b] <= RESET_VAL[b];
          sync_out[b] <= RESET_VAL[b];
        end
        else
        begin
          meta_reg[b] <= async_in[b];
          sync_out[b] <= meta_reg[b];
        end
      end
    end
  endgenerate

endmodule : spc_pin_sync

// file: hw/spc_pkg.sv
// spc_pkg: shared constants and carrier types of the pot command slave.
// assumes: a single mclk domain; pins are synchronised before use.
package spc_pkg;

  // data and counter widths
  localparam int unsigned DATA_W = 9;
  localparam int unsigned CNT_W  = 4;

  // location addresses
  localparam logic [3:0] ADDR_WIPER0 = 4'h0;
  localparam logic [3:0] ADDR_WIPER1 = 4'h1;
  localparam logic [3:0] ADDR_TERMINAL_CONNECT_CONTROL   = 4'h4;
  localparam logic [3:0] ADDR_COND   = 4'h5;

  // operation codes of the command byte
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_INC   = 2'h1;
  localparam logic [1:0] OP_DEC   = 2'h2;
  localparam logic [1:0] OP_READ  = 2'h3;

  // bit positions inside one command (count of rising edges seen)
  localparam logic [3:0] POS_DECODE   = 4'h5;
  localparam logic [3:0] POS_FLAG     = 4'h6;
  localparam logic [3:0] POS_BYTE_END = 4'h7;
  localparam logic [3:0] POS_WORD_END = 4'hf;

  // register values
  localparam logic [8:0] WIPER_RESET = 9'h080;
  localparam logic [8:0] TERMINAL_CONNECT_CONTROL_RESET  = 9'h1ff;
  localparam logic [8:0] FULL_SCALE  = 9'h100;
  localparam logic [8:0] ZERO_SCALE  = 9'h000;
  localparam logic [8:0] ONE_STEP    = 9'h001;

  // serial pins as they arrive
  typedef struct packed {
    logic cs_n;
    logic cs_hv;
    logic sck;
    logic sdi;
  } spc_pins_t;

  // idle level of the pins, used as synchroniser reset value
  localparam spc_pins_t PINS_IDLE = '{cs_n: 1'b1, cs_hv: 1'b0, sck: 1'b0, sdi: 1'b0};

  // volatile locations presented to the analog side
  typedef struct packed {
    logic [8:0] wiper0;
    logic [8:0] wiper1;
    logic [8:0] terminal_connect_control;
  } spc_pot_t;

endpackage : spc_pkg

// file: tb/spc_host_model.sv
// spc_host_model: behavioural spi host driving the pot command slave pins.
// assumes: mclk only paces the host; sck period 64 ns, driven off mclk edges.
`timescale 1ns/1ps
module spc_host_model (
  input  wire logic          mclk,
  input  wire logic          sdo,
  output spc_pkg::spc_pins_t pins
);
  import spc_pkg::*;
  logic mode_reg;

  // pins idle until the first frame
  initial pins = PINS_IDLE;

  // step n mclk edges then a small fixed delay
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cyc

  // open a frame with normal or high-voltage select
  task automatic open(input logic hv, input logic mode);
    mode_reg = mode;
    pins.sck = mode;
    wait_cyc(2);
    if (hv)
      pins.cs_hv = 1'b1;
    else
      pins.cs_n = 1'b0;
    wait_cyc(4);
  endtask : open

  // shift n bits msb first, sdo caught at the end of each high phase
  task automatic shift(input int n, input logic [15:0] din, output logic [15:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      pins.sck = 1'b0;
      pins.sdi = din[n-1-i];
      wait_cyc(4);
      pins.sck = 1'b1;
      wait_cyc(4);
      dout = {dout[14:0], sdo};
    end
  endtask : shift

  // back to idle sck level, deselect, scramble the released data line
  task automatic close();
    pins.sck = mode_reg;
    wait_cyc(4);
    pins.cs_n = 1'b1;
    pins.cs_hv = 1'b0;
    pins.sdi = ~pins.sdi;
    wait_cyc(6);
  endtask : close
endmodule : spc_host_model

// file: tb/test_spc_command_slave.sv
// test_spc_command_slave: self-checking bench of the pot command slave.
// assumes: spc_host_model drives the serial pins; design files are compiled first.
`timescale 1ns/1ps
module test_spc_command_slave;
  import spc_pkg::*;
  logic        mclk;
  logic        rst;
  spc_pins_t   pins;
  logic [8:0]  cond_bits;
  logic        sdo;
  spc_pot_t    pot;
  logic        err;
  logic        m11;
  logic        oe;
  int          n_errors = 0;
  int          compares = 0;

  spc_command_slave spc_command_slave_i (.mclk(mclk), .rst(rst), .pins_in(pins), .cond_bits(cond_bits),
    .sdo(sdo), .sdo_oe(oe), .pot(pot), .command_error_flag(err), .mode_one_one(m11));
  // released line reads the opposite of sdo, which is held high while released
  wire         sdo_line;
  assign sdo_line = oe ? sdo : ~sdo;
  spc_host_model spc_host_model_i (.mclk(mclk), .sdo(sdo_line), .pins(pins));

  // 125 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // one command through the host, sdo stream judged
  task automatic cmd(input int n, input logic [15:0] din, input logic [15:0] exp);
    logic [15:0] got;
    spc_host_model_i.shift(n, din, got);
    check("sdo", got, exp);
  endtask : cmd

  task automatic t_reset();
    check("wiper0", {7'h0, pot.wiper0}, {7'h0, WIPER_RESET});
    check("terminal_connect_control", {7'h0, pot.terminal_connect_control}, {7'h0, TERMINAL_CONNECT_CONTROL_RESET});
    check("oe", {15'h0, oe}, 16'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write_read();
    spc_host_model_i.open(1'b0, 1'b0);
    check("oe", {15'h0, oe}, 16'h1);
    check("mode", {15'h0, m11}, 16'h0);
    cmd(16, {ADDR_WIPER0, OP_WRITE, 1'b1, 9'h1a5}, 16'hffff);
    spc_host_model_i.close();
    check("wiper0", {7'h0, pot.wiper0}, 16'h01a5);
    spc_host_model_i.open(1'b0, 1'b0);
    cmd(16, {ADDR_WIPER0, OP_READ, 10'h0}, 16'hffa5);
    spc_host_model_i.close();
    check("oe", {15'h0, oe}, 16'h0);
    $display("test write_read done");
  endtask : t_write_read

  task automatic t_chain();
    spc_host_model_i.open(1'b1, 1'b1);
    check("mode", {15'h0, m11}, 16'h1);
    cmd(16, {ADDR_WIPER1, OP_WRITE, 10'h0ff}, 16'hffff);
    cmd(8, {8'h0, ADDR_WIPER1, OP_INC, 2'h0}, 16'h00ff);
    cmd(8, {8'h0, ADDR_WIPER1, OP_INC, 2'h0}, 16'h00ff);
    cmd(16, {ADDR_WIPER1, OP_READ, 10'h0}, 16'hff00);
    cmd(16, {ADDR_TERMINAL_CONNECT_CONTROL, OP_WRITE, 10'h0a5}, 16'hffff);
    cmd(16, {ADDR_WIPER1, OP_WRITE, 10'h001}, 16'hffff);
    cmd(8, {8'h0, ADDR_WIPER1, OP_DEC, 2'h0}, 16'h00ff);
    cmd(8, {8'h0, ADDR_WIPER1, OP_DEC, 2'h0}, 16'h00ff);
    cmd(16, {ADDR_COND, OP_READ, 10'h0}, {7'h7f, cond_bits});
    spc_host_model_i.close();
    check("wiper1", {7'h0, pot.wiper1}, 16'h0);
    check("terminal_connect_control", {7'h0, pot.terminal_connect_control}, 16'h00a5);
    $display("test chain done");
  endtask : t_chain

  task automatic t_error();
    spc_host_model_i.open(1'b0, 1'b0);
    cmd(8, {8'h0, ADDR_TERMINAL_CONNECT_CONTROL, OP_INC, 2'h0}, 16'h00fc);
    check("err", {15'h0, err}, 16'h1);
    cmd(16, {ADDR_WIPER0, OP_WRITE, 10'h0}, 16'h0);
    spc_host_model_i.close();
    check("err", {15'h0, err}, 16'h0);
    check("wiper0", {7'h0, pot.wiper0}, 16'h01a5);
    for (int a = 2; a < 17; a++)
    begin
      if (a == 4 || a == 5)
        continue;
      spc_host_model_i.open(1'b0, 1'b0);
      cmd(16, {(a == 16) ? ADDR_COND : a[3:0], (a == 16) ? OP_WRITE : OP_READ, 10'h0}, 16'hfc00);
      spc_host_model_i.close();
    end
    $display("test error done");
  endtask : t_error

  task automatic t_partial();
    spc_host_model_i.open(1'b0, 1'b0);
    cmd(12, {4'h0, ADDR_WIPER0, OP_WRITE, 6'h3f}, 16'h0fff);
    spc_host_model_i.close();
    check("wiper0", {7'h0, pot.wiper0}, 16'h01a5);
    spc_host_model_i.open(1'b0, 1'b1);
    cmd(16, {ADDR_WIPER0, OP_WRITE, 10'h07f}, 16'hffff);
    cmd(8, {8'h0, ADDR_WIPER0, OP_INC, 2'h0}, 16'h00ff);
    cmd(16, {ADDR_WIPER0, OP_READ, 10'h0}, 16'hfe80);
    spc_host_model_i.close();
    check("wiper0", {7'h0, pot.wiper0}, 16'h0080);
    $display("test partial done");
  endtask : t_partial

  // run cut short if it hangs
  initial
  begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    cond_bits = 9'h0c3;
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    t_reset();
    t_write_read();
    t_chain();
    t_error();
    t_partial();
    report_and_stop();
  end
endmodule : test_spc_command_slave
